// ---- shared/charger_status_pkg.sv ----
// Register map, field layout and status codes of the charger status bank
package charger_status_pkg;

    // Register offsets on the management port
    localparam logic [7:0] OFS_OPTIMIZED_INPUT_CURRENT_LIMIT = 8'h19;
    localparam logic [7:0] OFS_CHARGER_STATUS_FLAGS          = 8'h1B;
    localparam logic [7:0] OFS_CHARGE_PHASE_AND_SOURCE       = 8'h1C;

    // Port widths
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 16;
    localparam int LIMIT_W = 9;

    // Reset values
    localparam logic [LIMIT_W-1:0] LIMIT_RESET = 9'h000;
    localparam logic [2:0]         PHASE_RESET = 3'h0;
    localparam logic [3:0]         SOURCE_RESET = 4'h0;

    // Limit scale: 10 mA per code, span 100 mA to 3300 mA
    localparam int LIMIT_STEP_MA = 10;
    localparam int LIMIT_MIN_MA  = 100;
    localparam int LIMIT_MAX_MA  = 3300;
    localparam logic [LIMIT_W-1:0] LIMIT_MIN_CODE =
        LIMIT_W'(LIMIT_MIN_MA / LIMIT_STEP_MA);
    localparam logic [LIMIT_W-1:0] LIMIT_MAX_CODE =
        LIMIT_W'(LIMIT_MAX_MA / LIMIT_STEP_MA);

    // Bit positions in the flag register
    localparam int BIT_INPUT_CURRENT_REG = 7;
    localparam int BIT_INPUT_VOLTAGE_REG = 6;
    localparam int BIT_WATCHDOG_EXPIRED  = 5;
    localparam int BIT_POWER_GOOD        = 3;
    localparam int BIT_AUX_TWO_PRESENT   = 2;
    localparam int BIT_AUX_ONE_PRESENT   = 1;
    localparam int BIT_BUS_PRESENT       = 0;

    // Bit positions in the phase and source register
    localparam int PHASE_LSB       = 5;
    localparam int SOURCE_LSB      = 1;
    localparam int BIT_DETECT_DONE = 0;

    // Charge phase codes
    localparam logic [2:0] PHASE_RESERVED = 3'h5;

    // Input source codes that are not reserved
    localparam logic [3:0] SOURCE_LAST_LOW = 4'h8;
    localparam logic [3:0] SOURCE_DIRECT   = 4'hB;
    localparam logic [3:0] SOURCE_BACKUP   = 4'hC;

    // Analog comparator and regulation levels, crossing into clk
    typedef struct packed {
        logic input_current_reg_flag;
        logic input_voltage_reg_flag;
        logic power_good_flag;
        logic aux_input_two_present;
        logic aux_input_one_present;
        logic bus_input_present;
    } analog_flags_t;

    // Digital state from the charger controllers, already on clk
    typedef struct packed {
        logic                watchdog_expired_flag;
        logic [2:0]          charge_phase_code;
        logic [3:0]          input_source_code;
        logic                adapter_detect_done;
        logic                optimizer_active;
        logic [LIMIT_W-1:0]  optimizer_limit_code;
        logic [LIMIT_W-1:0]  limit_pin_setting;
    } ctrl_state_t;

    // Register access request
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage

// ---- design/level_sync.sv ----
// Two-stage synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else if (ce) begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule
`default_nettype wire

// ---- design/charger_status_readback.sv ----
// Read-only status register bank of the charger
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] Report clamped 9-bit input current limit
// [R2] Bit 7 set while current limiting
// [R3] Bit 6 set while voltage regulating
// [R4] Bit 5 set when watchdog expired
// [R5] Bit 3 reports power good
// [R6] Bit 2 set when aux input two present
// [R7] Bit 1 set when aux input one present
// [R8] Bit 0 set when bus input present
// [R9] Bits 7-5 hold charge phase code
// [R10] Bits 4-1 hold input source code
// [R11] Bit 0 flags adapter detection done
// [R12] Writes ignored; reserved bits read zero
module charger_status_readback
    import charger_status_pkg::*;
#(
    parameter int LIMIT_BITS = LIMIT_W
) (
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    // Charger internals
    input  wire analog_flags_t     analog_flags,
    input  wire ctrl_state_t       ctrl_state,
    // Register access port
    input  wire reg_req_t          reg_req,
    output var  logic [DATA_W-1:0] rdata,
    output var  logic              rvalid,
    output var  logic              addr_error
);

    analog_flags_t        flags_sync;
    logic [LIMIT_BITS-1:0] limit_value;
    logic [LIMIT_BITS-1:0] raw_limit;
    logic [LIMIT_BITS-1:0] next_limit;
    logic [7:0]           status_flags;
    logic [2:0]           charge_phase;
    logic [3:0]           input_source;
    logic                 detect_done;
    logic                 watchdog_flag;
    logic [DATA_W-1:0]    next_rdata;
    logic                 next_addr_error;

    // Clamp a raw limit code into the legal span
    function automatic logic [LIMIT_BITS-1:0] clamp_limit(
        input logic [LIMIT_BITS-1:0] raw
    );
        logic [LIMIT_BITS-1:0] result;
        result = raw;
        if (raw < LIMIT_BITS'(LIMIT_MIN_CODE)) begin
            result = LIMIT_BITS'(LIMIT_MIN_CODE);
        end else if (raw > LIMIT_BITS'(LIMIT_MAX_CODE)) begin
            result = LIMIT_BITS'(LIMIT_MAX_CODE);
        end
        return result;
    endfunction

    // True for a source code that has a defined meaning
    function automatic logic source_defined(input logic [3:0] code);
        return (code <= SOURCE_LAST_LOW) || (code == SOURCE_DIRECT) ||
               (code == SOURCE_BACKUP);
    endfunction

    // Comparator levels arrive from the analog side
    // [R5] comparator levels synchronised
    level_sync #(
        .WIDTH ($bits(analog_flags_t))
    ) i_level_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .async_in (analog_flags),
        .sync_out (flags_sync)
    );

    // Select optimizer or pin as the limit source
    // [R1] source select
    always_comb begin
        if (ctrl_state.optimizer_active) begin
            raw_limit = LIMIT_BITS'(ctrl_state.optimizer_limit_code);
        end else begin
            raw_limit = LIMIT_BITS'(ctrl_state.limit_pin_setting);
        end
    end

    // Clamp into the legal span; a zero setting reads as the minimum
    // [R1] span clamp
    assign next_limit = clamp_limit(raw_limit);

    // Current limit field, zero until first update after reset
    // [R1] limit register update
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limit_value <= LIMIT_BITS'(LIMIT_RESET);
        end else if (ce) begin
            limit_value <= next_limit;
        end
    end

    // Watchdog flag comes from same-clock logic
    // [R4] watchdog status capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_flag <= 1'b0;
        end else if (ce) begin
            watchdog_flag <= ctrl_state.watchdog_expired_flag;
        end
    end

    // Flag register assembly, bit 4 reserved at zero
    always_comb begin
        // [R12] bit 4 reserved
        status_flags = 8'h00;
        // [R2] current limiting flag
        status_flags[BIT_INPUT_CURRENT_REG] =
            flags_sync.input_current_reg_flag;
        // [R3] voltage regulation flag
        status_flags[BIT_INPUT_VOLTAGE_REG] =
            flags_sync.input_voltage_reg_flag;
        // [R4] watchdog expired flag
        status_flags[BIT_WATCHDOG_EXPIRED] = watchdog_flag;
        // [R5] power good flag
        status_flags[BIT_POWER_GOOD] = flags_sync.power_good_flag;
        // [R6] aux two presence
        status_flags[BIT_AUX_TWO_PRESENT] = flags_sync.aux_input_two_present;
        // [R7] aux one presence
        status_flags[BIT_AUX_ONE_PRESENT] = flags_sync.aux_input_one_present;
        // [R8] bus presence
        status_flags[BIT_BUS_PRESENT] = flags_sync.bus_input_present;
    end

    // Charge phase; a reserved code keeps the previous phase
    // [R9] phase code capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            charge_phase <= PHASE_RESET;
        end else if (ce && ctrl_state.charge_phase_code != PHASE_RESERVED) begin
            charge_phase <= ctrl_state.charge_phase_code;
        end
    end

    // Input source; a reserved code keeps the previous source
    // [R10] source code capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_source <= SOURCE_RESET;
        end else if (ce && source_defined(ctrl_state.input_source_code)) begin
            input_source <= ctrl_state.input_source_code;
        end
    end

    // Adapter detection completion
    // [R11] detection done flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            detect_done <= 1'b0;
        end else if (ce) begin
            detect_done <= ctrl_state.adapter_detect_done;
        end
    end

    // Read decode; unmapped addresses read zero and flag an error
    // [R12] read-only decode
    always_comb begin
        next_rdata      = '0;
        next_addr_error = 1'b0;
        unique case (reg_req.addr)
            OFS_OPTIMIZED_INPUT_CURRENT_LIMIT: begin
                // [R12] bits 15-9 stay zero
                next_rdata[LIMIT_BITS-1:0] = limit_value;
            end
            OFS_CHARGER_STATUS_FLAGS: begin
                next_rdata[7:0] = status_flags;
            end
            OFS_CHARGE_PHASE_AND_SOURCE: begin
                next_rdata[PHASE_LSB +: 3]  = charge_phase;
                next_rdata[SOURCE_LSB +: 4] = input_source;
                next_rdata[BIT_DETECT_DONE] = detect_done;
            end
            default: begin
                next_addr_error = 1'b1;
            end
        endcase
    end

    // Read answer pulse one cycle after the strobe
    // [R12] read answer pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
        end else if (ce) begin
            rvalid <= reg_req.rd;
        end
    end

    // Unmapped access of either kind flagged for one cycle
    // [R12] unmapped access flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_error <= 1'b0;
        end else if (ce) begin
            addr_error <= (reg_req.rd | reg_req.wr) & next_addr_error;
        end
    end

    // Read data held until the next read; writes change nothing
    // [R12] writes dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= '0;
        end else if (ce && reg_req.rd) begin
            rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// ---- bench/charger_status_checker.sv ----
// Port assertions for the charger status bank
`timescale 1ns/1ps
`default_nettype none
module charger_status_checker
    import charger_status_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              ce,
    input wire analog_flags_t     analog_flags,
    input wire ctrl_state_t       ctrl_state,
    input wire reg_req_t          reg_req,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              rvalid,
    input wire logic              addr_error
);
    logic map;
    // Request aims at one of the three registers
    assign map = reg_req.addr inside {OFS_OPTIMIZED_INPUT_CURRENT_LIMIT,
        OFS_CHARGER_STATUS_FLAGS, OFS_CHARGE_PHASE_AND_SOURCE};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Clamped limit the bank must show
    function automatic logic [8:0] lim(input ctrl_state_t s);
        logic [8:0] v;
        v = s.optimizer_active ? s.optimizer_limit_code : s.limit_pin_setting;
        return v < LIMIT_MIN_CODE ? LIMIT_MIN_CODE
             : v > LIMIT_MAX_CODE ? LIMIT_MAX_CODE : v;
    endfunction
    read_answer_a:
        assert property (ce && reg_req.rd && map |=> rvalid)
        else $error("mapped read not answered");
    bad_addr_a:
        assert property (ce && (reg_req.rd || reg_req.wr) && !map
            |=> addr_error)
        else $error("unmapped access not flagged");
    no_spurious_a:
        assert property (ce && !reg_req.rd |=> !rvalid)
        else $error("answer without a read");
    limit_upper_a:
        assert property (rvalid && $past(ce) &&
            $past(reg_req.addr) == OFS_OPTIMIZED_INPUT_CURRENT_LIMIT
            |-> rdata[15:9] == 7'h00)
        else $error("limit reserved bits set");
    // Read at t-1 returns the register loaded at t-2
    limit_clamp_a:
        assert property (rvalid && $past(ce) && $past(ce, 2) &&
            $past(rst_b, 2) &&
            $past(reg_req.addr) == OFS_OPTIMIZED_INPUT_CURRENT_LIMIT
            |-> rdata[8:0] == lim($past(ctrl_state, 2)))
        else $error("limit value wrong");
    flag_spare_a:
        assert property (rvalid && $past(ce) &&
            $past(reg_req.addr) == OFS_CHARGER_STATUS_FLAGS
            |-> rdata[15:8] == 8'h00 && !rdata[4])
        else $error("flag reserved bits set");
    phase_upper_a:
        assert property (rvalid && $past(ce) &&
            $past(reg_req.addr) == OFS_CHARGE_PHASE_AND_SOURCE
            |-> rdata[15:8] == 8'h00)
        else $error("phase register upper byte set");
    watchdog_bit_a:
        assert property (rvalid && $past(ce) && $past(ce, 2) &&
            $past(rst_b, 2) &&
            $past(reg_req.addr) == OFS_CHARGER_STATUS_FLAGS
            |-> rdata[BIT_WATCHDOG_EXPIRED] ==
            $past(ctrl_state.watchdog_expired_flag, 2))
        else $error("watchdog bit wrong");
    detect_bit_a:
        assert property (rvalid && $past(ce) && $past(ce, 2) &&
            $past(rst_b, 2) &&
            $past(reg_req.addr) == OFS_CHARGE_PHASE_AND_SOURCE
            |-> rdata[BIT_DETECT_DONE] ==
            $past(ctrl_state.adapter_detect_done, 2))
        else $error("detect bit wrong");
endmodule
bind charger_status_readback charger_status_checker i_charger_status_checker (
    .clk, .rst_b, .ce, .analog_flags, .ctrl_state, .reg_req, .rdata, .rvalid,
    .addr_error);
`default_nettype wire

// ---- bench/status_host.sv ----
// Host model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module status_host
    import charger_status_pkg::*;
(
    input  wire logic              clk,
    output var  reg_req_t          reg_req,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic              rvalid,
    input  wire logic              addr_error
);
    initial reg_req = '0;
    // One strobe, released lines inverted, bounded wait for the answer;
    // a write has no answer beyond the error pulse, so it ends at once
    task automatic access(input logic wr, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic e,
        output logic ok);
        @(posedge clk);
        reg_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            ok = rvalid || addr_error || wr;
        end
        q = rdata;
        e = addr_error;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_charger_status_readback.sv ----
// Self-checking bench for the charger status bank
`timescale 1ns/1ps
`default_nettype none
module tb_charger_status_readback;
    import charger_status_pkg::*;
    logic clk = 0, rst_b = 0, ce = 1, e, ok;
    analog_flags_t analog_flags = '0;
    ctrl_state_t ctrl_state = '0;
    reg_req_t reg_req;
    logic [15:0] rdata, q, w;
    logic rvalid, addr_error;
    logic [8:0] v, lims [7] = '{9'h000, 9'h009, 9'h00A, 9'h0C8, 9'h14A,
        9'h14B, 9'h1FF};
    logic [2:0] ph = 3'h0;
    logic [3:0] src = 4'h0;
    int pos [7] = '{0, 1, 2, 3, 6, 7, 5};
    int err_count = 0, total_checks = 0;
    charger_status_readback i_charger_status_readback (.clk, .rst_b, .ce,
        .analog_flags, .ctrl_state, .reg_req, .rdata, .rvalid, .addr_error);
    status_host i_status_host (.clk, .reg_req, .rdata, .rvalid, .addr_error);
    initial forever #2.5 clk = ~clk;
    task automatic check(input logic [17:0] seen, input logic [17:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] want);
        i_status_host.access(1'b0, a, 16'h0000, q, e, ok);
        check({ok, e, q}, {2'b10, want});
        // A read that never came back ends the run
        if (!ok) tally_and_finish();
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic err);
        i_status_host.access(1'b1, a, 16'hFFFF, q, e, ok);
        check({ok, e, 16'h0000}, {1'b1, err, 16'h0000});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // Power-on values, limit clamped up from zero
        rd_chk(OFS_OPTIMIZED_INPUT_CURRENT_LIMIT, 16'h000A);
        rd_chk(OFS_CHARGER_STATUS_FLAGS, 16'h0000);
        rd_chk(OFS_CHARGE_PHASE_AND_SOURCE, 16'h0000);
        // Limit from either source across the clamp edges
        foreach (lims[k]) for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            ctrl_state.optimizer_active <= s[0];
            ctrl_state.optimizer_limit_code <= s[0] ? lims[k] : 9'h123;
            ctrl_state.limit_pin_setting <= s[0] ? 9'h050 : lims[k];
            repeat (4) @(posedge clk);
            v = lims[k] < 9'h00A ? 9'h00A
              : lims[k] > 9'h14A ? 9'h14A : lims[k];
            rd_chk(OFS_OPTIMIZED_INPUT_CURRENT_LIMIT, {7'h00, v});
        end
        // One flag at a time lands on its own bit
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            analog_flags <= 6'(i < 6 ? 1 << i : 0);
            ctrl_state.watchdog_expired_flag <= (i == 6);
            repeat (4) @(posedge clk);
            w = 16'h0001 << pos[i];
            rd_chk(OFS_CHARGER_STATUS_FLAGS, w);
        end
        // Every phase and source code, reserved ones keep the old value
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            ctrl_state.charge_phase_code <= k[2:0];
            ctrl_state.input_source_code <= k[3:0];
            ctrl_state.adapter_detect_done <= k[0];
            repeat (4) @(posedge clk);
            if (k[2:0] != 3'h5) ph = k[2:0];
            if (!(k[3:0] inside {4'h9, 4'hA, 4'hD, 4'hE, 4'hF})) src = k[3:0];
            w = {8'h00, ph, src, k[0]};
            rd_chk(OFS_CHARGE_PHASE_AND_SOURCE, w);
        end
        // Writes are silent and change nothing, unmapped ones flag an error
        wr_chk(OFS_CHARGE_PHASE_AND_SOURCE, 1'b0);
        wr_chk(OFS_CHARGER_STATUS_FLAGS, 1'b0);
        wr_chk(OFS_OPTIMIZED_INPUT_CURRENT_LIMIT, 1'b0);
        w = {8'h00, ph, src, 1'b1};
        rd_chk(OFS_CHARGE_PHASE_AND_SOURCE, w);
        rd_chk(OFS_CHARGER_STATUS_FLAGS, 16'h0020);
        rd_chk(OFS_OPTIMIZED_INPUT_CURRENT_LIMIT, 16'h014A);
        wr_chk(8'h1A, 1'b1);
        // Unmapped read answers zero together with the error pulse
        i_status_host.access(1'b0, 8'h1A, 16'h0000, q, e, ok);
        check({ok, e, q}, {2'b11, 16'h0000});
        // Low enable freezes the synchroniser, which catches up afterwards
        @(posedge clk);
        ce <= 1'b0;
        analog_flags.bus_input_present <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        rd_chk(OFS_CHARGER_STATUS_FLAGS, 16'h0020);
        rd_chk(OFS_CHARGER_STATUS_FLAGS, 16'h0021);
        tally_and_finish();
    end
endmodule
`default_nettype wire
